// ### shared/ewp_pkg.sv
// shared package: register map, fields, timing and state of the protect logic
package ewp_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] EWP_CMD_OFS = 8'h00;   // command word, write starts
    localparam logic [7:0] EWP_STS_OFS = 8'h04;   // decision and flag status

    // command register fields
    localparam int EWP_CTL_LSB  = 0;              // control byte, bits 7:0
    localparam int EWP_ADDR_LSB = 8;              // word address, bits 15:8

    // status register bit positions
    localparam int EWP_STS_ACK   = 0;             // last command acknowledged
    localparam int EWP_STS_STORE = 1;             // last write may be stored
    localparam int EWP_STS_PERM  = 2;             // permanent flag
    localparam int EWP_STS_REV   = 3;             // reversible flag
    localparam int EWP_STS_BUSY  = 4;             // write cycle running
    localparam int EWP_STS_DONE  = 5;             // decision valid

    // control byte preambles and selector fields
    localparam logic [3:0] EWP_PRE_ARRAY   = 4'hA; // array access
    localparam logic [3:0] EWP_PRE_PROTECT = 4'h6; // protect flag commands
    localparam logic [2:0] EWP_SEL_SET_REV = 3'h1; // set / query reversible
    localparam logic [2:0] EWP_SEL_CLR_REV = 3'h3; // clear reversible

    // internal write cycle time
    localparam int EWP_TWR_NS = 5000000;          // self-timed write, 5 ms
    localparam int EWP_CLK_NS = 4;                // pclk period
    localparam int EWP_TWR_CYCLES =
        (EWP_TWR_NS + EWP_CLK_NS - 1) / EWP_CLK_NS;
    localparam int EWP_TMR_W = 21;                // holds 1,250,000

    // reset values
    localparam logic [31:0] EWP_RD_ZERO = 32'h0000_0000;

    typedef logic [EWP_TMR_W-1:0] ewp_tmr_t;

    // sequencer states, gray along idle, eval, wait
    typedef enum logic [1:0] {
        EWP_IDLE = 2'b00,
        EWP_EVAL = 2'b01,
        EWP_WAIT = 2'b11
    } ewp_fsm_t;

    // whole state of the block
    typedef struct packed {
        ewp_fsm_t    fsm;                         // sequencer
        ewp_tmr_t    timer;                       // write cycle countdown
        logic [7:0]  ctl;                         // latched control byte
        logic [7:0]  waddr;                       // latched word address
        logic        perm;                        // permanent protect flag
        logic        rev;                         // reversible protect flag
        logic        ack;                         // acknowledge decision
        logic        store;                       // data may be stored
        logic        done;                        // decision valid
        logic        pready;                      // apb ready
        logic        pslverr;                     // apb error
        logic [31:0] prdata;                      // apb read data
    } ewp_state_t;

endpackage

// ### rtl/ewp_protect_ctrl.sv
// write-protect decision logic for a two-wire eeprom, apb controlled
//
// Operation
// RL1 - any flag set: writes store 80h-FFh only
// RL2 - no flags: array write acked, full array
// RL3 - permanent query: nack if set, else ack
// RL4 - reversible query: nack if set, else ack
// RL5 - set permanent nacked when already set
// RL6 - pin low: set permanent acked, flag sets
// RL7 - set reversible nacked when already set
// RL8 - pin low: set reversible acked, flag sets
// RL9 - permanent set: clear reversible nacked
// RL10 - pin low, permanent clear: clear reversible
// RL11 - pin high: array writes acked, none stored
// RL12 - pin high: set commands acked, no effect
// RL13 - pin high: clear reversible acked, no effect
// RL14 - array reads always acked; here nacked while a write cycle runs
// RL15 - blocked write still runs write cycle
// RL16 - protect commands use preamble 0110
// RL17 - reversible set 62h, clear 66h, high voltage
// RL18 - query uses set byte with read bit
// RL19 - flags guard only locations 00h-7Fh
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps

module ewp_protect_ctrl #(
    // write cycle length in pclk cycles, shorten for simulation
    parameter int       WRITE_CYCLES = ewp_pkg::EWP_TWR_CYCLES,
    // flag image loaded at reset, stands in for the nonvolatile cells
    parameter bit       PERM_INIT    = 1'b0,
    parameter bit       REV_INIT     = 1'b0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        write_protect_pin,
    input  wire logic        addr_select_bit0,
    input  wire logic        addr_select_bit1,
    input  wire logic        addr_select_bit2,
    input  wire logic        high_voltage_level,
    output logic             cmd_ack,
    output logic             cmd_store,
    output logic             cmd_done,
    output logic             write_busy,
    output logic             permanent_protect_flag,
    output logic             reversible_protect_flag
);

    // registered state and its next value
    ewp_pkg::ewp_state_t st_reg;      // all flip-flops of the block
    ewp_pkg::ewp_state_t st_next;     // combinational copy

    // bus decode
    logic       access;               // access phase of a transfer
    logic       hit_cmd;              // command register addressed
    logic       hit_sts;              // status register addressed
    logic       take_wr;              // write completes this edge
    logic [31:0] rd_mux;              // read data before the flop

    // command decode
    logic [3:0] preamble;             // upper nibble of control byte
    logic [2:0] sel;                  // bits 3:1 of control byte
    logic       rd_bit;               // read/write bit
    logic [2:0] pins;                 // address select pin levels
    logic       is_array;             // array read or write
    logic       is_rev_set;           // set or query reversible
    logic       is_rev_clr;           // clear reversible
    logic       is_perm;              // set or query permanent
    logic       busy;                 // write cycle still running
    logic       any_flag;             // lower half guarded by software

    // bus decode and read mux
    always_comb begin
        access  = psel & penable;
        hit_cmd = (paddr == ewp_pkg::EWP_CMD_OFS);
        hit_sts = (paddr == ewp_pkg::EWP_STS_OFS);
        // a write takes effect only on the edge that sees pready high
        take_wr = access & st_reg.pready & pwrite & hit_cmd;
        rd_mux  = ewp_pkg::EWP_RD_ZERO;
        if (hit_cmd) begin
            rd_mux[ewp_pkg::EWP_CTL_LSB  +: 8] = st_reg.ctl;
            rd_mux[ewp_pkg::EWP_ADDR_LSB +: 8] = st_reg.waddr;
        end else if (hit_sts) begin
            rd_mux[ewp_pkg::EWP_STS_ACK]   = st_reg.ack;
            rd_mux[ewp_pkg::EWP_STS_STORE] = st_reg.store;
            rd_mux[ewp_pkg::EWP_STS_PERM]  = st_reg.perm;
            rd_mux[ewp_pkg::EWP_STS_REV]   = st_reg.rev;
            rd_mux[ewp_pkg::EWP_STS_BUSY]  = busy;
            rd_mux[ewp_pkg::EWP_STS_DONE]  = st_reg.done;
        end
    end

    // control byte decode against the pin levels
    always_comb begin
        preamble = st_reg.ctl[7:4];
        sel      = st_reg.ctl[3:1];
        rd_bit   = st_reg.ctl[0];
        pins     = {addr_select_bit2, addr_select_bit1, addr_select_bit0};
        busy     = (st_reg.timer != '0);
        any_flag = st_reg.perm | st_reg.rev;
        is_array = (preamble == ewp_pkg::EWP_PRE_ARRAY);
        // reversible commands need bit0 pin at high voltage
        is_rev_set = (preamble == ewp_pkg::EWP_PRE_PROTECT) // RL16
                   & high_voltage_level                    // RL17
                   & (sel == ewp_pkg::EWP_SEL_SET_REV)
                   & ~addr_select_bit2 & ~addr_select_bit1;
        // clear has no read form; the read bit must be low
        is_rev_clr = (preamble == ewp_pkg::EWP_PRE_PROTECT) // RL16
                   & high_voltage_level                    // RL17
                   & (sel == ewp_pkg::EWP_SEL_CLR_REV)
                   & ~addr_select_bit2 & addr_select_bit1
                   & ~rd_bit;
        // permanent commands match the plain pin strapping
        is_perm = (preamble == ewp_pkg::EWP_PRE_PROTECT)    // RL16
                & ~high_voltage_level
                & (sel == pins);
    end

    // next state: bus answer, sequencer, decision and flag update
    always_comb begin
        st_next = st_reg;

        // ready is a single-cycle answer one edge into the access
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;
        if (access & ~st_reg.pready) begin
            st_next.pready  = 1'b1;
            // unmapped offsets answer with an error and zero data
            st_next.pslverr = ~(hit_cmd | hit_sts);
            st_next.prdata  = rd_mux;
        end

        // write cycle countdown runs in every state
        if (busy) begin
            st_next.timer = st_reg.timer - 1'b1;
        end

        case (st_reg.fsm)
            ewp_pkg::EWP_IDLE: begin
                // nothing pending
            end
            ewp_pkg::EWP_EVAL: begin
                st_next.done  = 1'b1;
                st_next.ack   = 1'b0;
                st_next.store = 1'b0;
                if (busy) begin
                    // inputs are disabled while writing: no answer
                    st_next.ack = 1'b0;
                end else if (is_array) begin
                    st_next.ack = 1'b1;                       // RL14 RL2
                    if (~rd_bit) begin
                        // pin high guards all, flags the lower half
                        st_next.store = ~write_protect_pin    // RL11
                            & (~any_flag                      // RL2
                               | st_reg.waddr[7]);            // RL1 RL19
                    end
                end else if (is_rev_set) begin
                    // query and set share one byte, read bit apart
                    st_next.ack = ~st_reg.rev;            // RL4 RL7 RL18
                    if (~rd_bit & ~st_reg.rev & ~write_protect_pin) begin
                        st_next.rev = 1'b1;                   // RL8 RL12
                    end
                end else if (is_rev_clr) begin
                    st_next.ack = ~st_reg.perm;               // RL9
                    if (~st_reg.perm & ~write_protect_pin) begin
                        st_next.rev = 1'b0;                   // RL10 RL13
                    end
                end else if (is_perm) begin
                    st_next.ack = ~st_reg.perm;           // RL3 RL5 RL18
                    // address and data are don't-care; never cleared
                    if (~rd_bit & ~st_reg.perm & ~write_protect_pin) begin
                        st_next.perm = 1'b1;                  // RL6 RL12
                    end
                end
                // any acked write starts the timed cycle, stored or not
                if (~busy & ~rd_bit & (is_array | is_rev_set
                        | is_rev_clr | is_perm)
                        & st_next.ack) begin
                    st_next.timer = ewp_pkg::ewp_tmr_t'(WRITE_CYCLES); // RL15
                    st_next.fsm   = ewp_pkg::EWP_WAIT;
                end else if (busy) begin
                    st_next.fsm = ewp_pkg::EWP_WAIT;
                end else begin
                    st_next.fsm = ewp_pkg::EWP_IDLE;
                end
            end
            ewp_pkg::EWP_WAIT: begin
                // leave once the countdown is about to expire
                if (st_reg.timer <= ewp_pkg::ewp_tmr_t'(1)) begin
                    st_next.fsm = ewp_pkg::EWP_IDLE;
                end
            end
            default: begin
                st_next.fsm = ewp_pkg::EWP_IDLE;
            end
        endcase

        // a new command wins over any state; evaluated next cycle
        if (take_wr) begin
            st_next.ctl   = pwdata[ewp_pkg::EWP_CTL_LSB  +: 8];
            st_next.waddr = pwdata[ewp_pkg::EWP_ADDR_LSB +: 8];
            st_next.done  = 1'b0;
            st_next.fsm   = ewp_pkg::EWP_EVAL;
        end
    end

    // state register; flags reload the stored image on reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg         <= '0;
            st_reg.fsm     <= ewp_pkg::EWP_IDLE;
            st_reg.perm    <= PERM_INIT;
            st_reg.rev     <= REV_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops; write_busy decodes the sequencer state
    assign prdata                  = st_reg.prdata;
    assign pready                  = st_reg.pready;
    assign pslverr                 = st_reg.pslverr;
    assign cmd_ack                 = st_reg.ack;
    assign cmd_store               = st_reg.store;
    assign cmd_done                = st_reg.done;
    assign write_busy              = (st_reg.fsm == ewp_pkg::EWP_WAIT);
    assign permanent_protect_flag  = st_reg.perm;
    assign reversible_protect_flag = st_reg.rev;

endmodule // ewp_protect_ctrl

// ### verif/ewp_pin_model.sv
// far side pin straps: protect pin, address select pins and high voltage
`timescale 1ns/1ps
module ewp_pin_model (
    input  wire logic [3:0] pin_req,    // {protect, high voltage, bit1, bit0}
    output logic            write_protect_pin,
    output logic            addr_select_bit0,
    output logic            addr_select_bit1,
    output logic            addr_select_bit2,
    output logic            high_voltage_level
);
    // bit2 strapped to ground, which both reversible commands need
    assign addr_select_bit2   = 1'b0;
    assign addr_select_bit1   = pin_req[1];
    // a pin raised to high voltage also reads as a logic one
    assign addr_select_bit0   = pin_req[0] | pin_req[2];
    assign high_voltage_level = pin_req[2];
    assign write_protect_pin  = pin_req[3];
endmodule // ewp_pin_model

// ### verif/ewp_protect_monitor.sv
// assertion checker for the write protect decision logic
`timescale 1ns/1ps
module ewp_protect_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        high_voltage_level,
    input wire logic        write_protect_pin,
    input wire logic        cmd_ack,
    input wire logic        cmd_store,
    input wire logic        cmd_done,
    input wire logic        write_busy,
    input wire logic        permanent_protect_flag,
    input wire logic        reversible_protect_flag
);
    logic [15:0] cmd_reg;   // word address and control byte of last command
    logic        cmd_wr;    // command word accepted at this edge
    assign cmd_wr = psel && penable && pready && pwrite && paddr == 8'h00;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // keep the last command so decisions can be tied to their cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cmd_reg <= 16'h0000;
        else if (cmd_wr) cmd_reg <= pwdata[15:0];
    end
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("ready not one cycle after access start");
    a_done_cycle: assert property (cmd_wr |=> !cmd_done ##1 cmd_done)
        else $error("decision not valid two cycles after command");
    a_perm_kept: assert property (!$fell(permanent_protect_flag))
        else $error("permanent flag cleared");
    a_pin_freeze: assert property ($rose(cmd_done) && $past(write_protect_pin)
        |-> $stable(permanent_protect_flag) && $stable(reversible_protect_flag))
        else $error("flag changed while protect pin high");
    a_pin_nostore: assert property ($rose(cmd_done) &&
        $past(write_protect_pin) |-> !cmd_store)
        else $error("store allowed while protect pin high");
    a_array_ack: assert property ($rose(cmd_done) && cmd_reg[7:4] == 4'hA
        && !$past(write_busy, 3) |-> cmd_ack)
        else $error("array command not acknowledged");
    a_upper_only: assert property ($rose(cmd_done) && cmd_store &&
        (permanent_protect_flag || reversible_protect_flag) |-> cmd_reg[15])
        else $error("lower half stored while protected");
    a_perm_clr: assert property ($rose(cmd_done) &&
        $past(permanent_protect_flag) && cmd_reg[7:0] == 8'h66 |-> !cmd_ack)
        else $error("clear acknowledged with permanent flag");
    a_rev_nack: assert property ($rose(cmd_done) && $past(high_voltage_level)
        && $past(reversible_protect_flag) && cmd_reg[7:1] == 7'h31
        |-> !cmd_ack) else $error("reversible set flag acked");
    a_busy_run: assert property ($rose(write_busy) |-> cmd_ack && !cmd_reg[0]
        ##1 write_busy [*7]) else $error("write cycle too short");
    a_flag_ack: assert property ($changed(reversible_protect_flag) |->
        cmd_ack && $rose(cmd_done))
        else $error("reversible flag moved without acked command");
endmodule // ewp_protect_monitor
bind ewp_protect_ctrl ewp_protect_monitor u_mon (.*);

// ### verif/ewp_protect_ctrl_tb.sv
// self-checking bench for the write protect decision logic
`timescale 1ns/1ps
module ewp_protect_ctrl_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, rerr, cmd_ack, cmd_store;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0]  pin_req = 4'h0;   // {protect, high voltage, bit1, bit0}
    logic        write_protect_pin, addr_select_bit0, addr_select_bit1;
    logic        addr_select_bit2, high_voltage_level, cmd_done, write_busy;
    logic        permanent_protect_flag, reversible_protect_flag;
    int          n_errors = 0, checks_done = 0;
    always #2 pclk = ~pclk;
    ewp_protect_ctrl #(.WRITE_CYCLES(20)) dut (.*);
    ewp_pin_model u_pins (.*);
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // a bound that runs out is a mismatch and ends the run
    task automatic must(input logic ok);
        if (ok !== 1'b1) begin
            check("handshake", 0, 1);
            close_out();
        end
    endtask
    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        // look at ready mid-cycle, where it has settled, never in the
        // time step of the edge that launches it
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        must(pready);
        rdata = prdata;
        rerr = pslverr;
        // the next rising edge samples ready high and ends the transfer
        @(posedge pclk);
        {psel, penable} <= 2'b00;
    endtask
    // command with given pins; e is {rev, perm, store, ack} expected
    task automatic cmd(input [7:0] c, a, input [3:0] pins, input [3:0] e);
        int n;
        n = 0;
        pin_req <= pins;
        apb(1'b1, 8'h00, {16'h0, a, c});
        do begin
            @(negedge pclk);
            n++;
        end while (cmd_done !== 1'b1 && n < 16);
        must(cmd_done);
        check("ports", {reversible_protect_flag, permanent_protect_flag,
                        cmd_store, cmd_ack}, e);
        apb(1'b0, 8'h04, 0);
        // busy must run even when the write itself was blocked
        check("status", rdata[5:0], {1'b1, e[0] & ~c[0], e});
        n = 0;
        while (write_busy !== 1'b0 && n < 64) begin
            @(negedge pclk);
            n++;
        end
        must(!write_busy);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h04, 0);
        check("reset status", rdata, 32'h0);
        apb(1'b1, 8'h04, 32'hFF);
        apb(1'b0, 8'h08, 0);
        check("unmapped error", rerr, 1'b1);
        apb(1'b0, 8'h04, 0);
        check("status after write", rdata, 32'h0);
        $display("test registers done");
        cmd(8'hA0, 8'h10, 4'h0, 4'h3);
        cmd(8'hA1, 8'h10, 4'h0, 4'h1);
        cmd(8'h61, 8'h00, 4'h0, 4'h1);
        cmd(8'h63, 8'h00, 4'h4, 4'h1);
        cmd(8'h50, 8'h00, 4'h0, 4'h0);
        cmd(8'h62, 8'h00, 4'h0, 4'h0);
        $display("test unprotected done");
        cmd(8'hA0, 8'h10, 4'h8, 4'h1);
        cmd(8'hA1, 8'h10, 4'h8, 4'h1);
        cmd(8'h62, 8'h00, 4'hC, 4'h1);
        cmd(8'h60, 8'h00, 4'h8, 4'h1);
        cmd(8'h66, 8'h00, 4'hE, 4'h1);
        $display("test protect pin done");
        cmd(8'h62, 8'h00, 4'h4, 4'h9);
        cmd(8'h63, 8'h00, 4'h4, 4'h8);
        cmd(8'h62, 8'h00, 4'hC, 4'h8);
        cmd(8'hA0, 8'h7F, 4'h0, 4'h9);
        cmd(8'hA0, 8'h80, 4'h0, 4'hB);
        cmd(8'h66, 8'h00, 4'hE, 4'h9);
        cmd(8'h66, 8'h00, 4'h6, 4'h1);
        $display("test reversible done");
        cmd(8'h60, 8'h00, 4'h0, 4'h5);
        cmd(8'h61, 8'h00, 4'h0, 4'h4);
        cmd(8'h60, 8'h00, 4'h8, 4'h4);
        cmd(8'h66, 8'h00, 4'h6, 4'h4);
        cmd(8'hA0, 8'h00, 4'h0, 4'h5);
        cmd(8'hA0, 8'hFF, 4'h0, 4'h7);
        cmd(8'hA1, 8'h00, 4'h0, 4'h5);
        $display("test permanent done");
        close_out();
    end
endmodule // ewp_protect_ctrl_tb
